// ===== design/eag_map.svh
// Purpose: constants for the effective address generator
// Assumes: 16-bit core, 20-bit physical space
// Notes: definitions only
`ifndef EAG_MAP_SVH
`define EAG_MAP_SVH
`define EAG_ADDR_W 16
`define EAG_PHYS_W 20
`define EAG_SEG_SHIFT 4
`define EAG_PORT_DIRECT_W 8
`define EAG_BCD_DIGIT_W 4
`define EAG_ZERO16 16'h0000
`define EAG_STEP_BYTE 16'h0001
`define EAG_STEP_WORD 16'h0002
`endif

// ===== design/eag_pkg.sv
// Purpose: types for the effective address generator
// Assumes: widths are written out here; the map header is not included
// Notes: none
package eag_pkg;
    typedef enum logic [2:0] {
        eag_mode_direct, eag_mode_indirect, eag_mode_based, eag_mode_indexed,
        eag_mode_based_index, eag_mode_string, eag_mode_io_direct, eag_mode_io_indirect
    } eag_mode_type;
    typedef enum logic [0:0] {eag_base_general, eag_base_pointer} eag_base_type;
    typedef enum logic [0:0] {eag_index_source, eag_index_dest} eag_index_type;
    typedef enum logic [1:0] {eag_seg_data, eag_seg_extra, eag_seg_stack, eag_seg_code} eag_seg_type;
    typedef enum logic [1:0] {eag_ind_base, eag_ind_index, eag_ind_any} eag_ind_type;
    typedef struct packed {
        logic valid;
        eag_mode_type mode;
        eag_base_type base_sel;
        eag_index_type index_sel;
        eag_ind_type ind_src;
        logic [2:0] any_reg;
        logic disp_wide;
        logic [15:0] disp;
        logic override;
        eag_seg_type override_seg;
        logic str_word;
        logic str_down;
        logic str_dest;
        logic str_repeat;
    } eag_req_type;
    typedef struct packed {
        logic [15:0] general_base_reg;
        logic [15:0] base_pointer_reg;
        logic [15:0] source_index_reg;
        logic [15:0] dest_index_reg;
        logic [15:0] port_pointer_reg;
        logic [15:0] data_segment_reg;
        logic [15:0] extra_segment_reg;
        logic [15:0] stack_segment_reg;
        logic [7:0][15:0] gen_regs;
    } eag_regs_type;
    typedef struct packed {
        logic valid;
        logic is_io;
        logic [15:0] offset;
        eag_seg_type seg;
        logic [19:0] phys;
        logic index_upd;
        logic [15:0] next_source_index;
        logic [15:0] next_dest_index;
    } eag_resp_type;
    typedef struct packed {
        eag_resp_type resp;
    } eag_state_type;
endpackage

// ===== design/eag_core.sv
// Purpose: effective address, segment choice and port number for the core
// Assumes: decoder gives mode and displacement; register file values are stable
// Notes: one-cycle latency, result in a register
// How it works
// RULE1 - base is general or pointer; index source/dest
// RULE2 - pointer base defaults to stack, override allowed
// RULE3 - direct mode uses displacement only
// RULE4 - register indirect takes register unchanged
// RULE5 - indirect jump may use any general register
// RULE6 - based adds displacement and base
// RULE7 - indexed adds displacement and index
// RULE8 - based index sums base, index, displacement
// RULE9 - strings use source/dest index implicitly
// RULE10 - repeated strings step both index registers
// RULE11 - source with data, dest with extra
// RULE12 - strings span up to full segment
// RULE13 - memory-mapped ports use any memory mode
// RULE14 - direct port number is 8-bit immediate
// RULE15 - indirect port number from port pointer
// RULE16 - signed operands are two's complement
// RULE17 - packed decimal: one digit per nibble
// RULE18 - long pointer is selector plus offset
// RULE19 - offset is unsigned 16-bit distance
// RULE20 - physical is shifted segment plus offset
// RULE21 - displacement is 8 or 16 bits
// RULE22 - sum wraps at 16 bits, short disp sign-extended
// RULE23 - non-pointer forms default to data segment
`timescale 1ns/10ps
`include "eag_map.svh"
module eag_core
    import eag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire eag_req_type req,
    input wire eag_regs_type regs,
    input wire logic [15:0] ptr_selector,
    input wire logic [15:0] ptr_offset,
    output eag_resp_type resp,
    output logic [19:0] long_ptr_phys,
    output logic [7:0] bcd_low_digit,
    output logic [7:0] bcd_high_digit,
    output logic [15:0] sext_disp
);
    // ****************************************
    // state
    // ****************************************
    eag_state_type state;
    eag_state_type next_state;
    logic [19:0] lp_phys;
    logic [19:0] next_lp_phys;
    logic [7:0] bcd_lo;
    logic [7:0] bcd_hi;
    logic [15:0] sx;

    function automatic logic [19:0] phys_of(input logic [15:0] seg, input logic [15:0] off);
        phys_of = {seg, 4'h0} + {4'h0, off}; // see RULE20
    endfunction

    // ****************************************
    // address formation
    // ****************************************
    always_comb begin
        logic [15:0] disp_ext;
        logic [15:0] base_val;
        logic [15:0] index_val;
        logic [15:0] step;
        logic [15:0] seg_val;
        eag_seg_type dflt;
        disp_ext = req.disp_wide ? req.disp : {{8{req.disp[7]}}, req.disp[7:0]}; // see RULE21 see RULE22 see RULE16
        base_val = (req.base_sel == eag_base_pointer) ? regs.base_pointer_reg : regs.general_base_reg; // see RULE1
        index_val = (req.index_sel == eag_index_dest) ? regs.dest_index_reg : regs.source_index_reg; // see RULE1
        step = req.str_word ? `EAG_STEP_WORD : `EAG_STEP_BYTE;
        dflt = eag_seg_data; // see RULE23
        seg_val = regs.data_segment_reg;
        next_state = state;
        next_state.resp.valid = req.valid;
        next_state.resp.is_io = 1'b0;
        next_state.resp.index_upd = 1'b0;
        next_state.resp.next_source_index = regs.source_index_reg;
        next_state.resp.next_dest_index = regs.dest_index_reg;
        // offsets are 16-bit sums, carry out dropped so they wrap in segment
        unique case (req.mode)
            eag_mode_direct: begin
                next_state.resp.offset = disp_ext; // see RULE3
            end
            eag_mode_indirect: begin
                unique case (req.ind_src)
                    eag_ind_base: next_state.resp.offset = base_val; // see RULE4
                    eag_ind_index: next_state.resp.offset = index_val; // see RULE4
                    default: next_state.resp.offset = regs.gen_regs[req.any_reg]; // see RULE5
                endcase
                if (req.ind_src == eag_ind_base && req.base_sel == eag_base_pointer) begin
                    dflt = eag_seg_stack; // see RULE2
                end
            end
            eag_mode_based: begin
                next_state.resp.offset = 16'(disp_ext + base_val); // see RULE6 see RULE22
                if (req.base_sel == eag_base_pointer) begin
                    dflt = eag_seg_stack; // see RULE2
                end
            end
            eag_mode_indexed: begin
                next_state.resp.offset = 16'(disp_ext + index_val); // see RULE7 see RULE22
            end
            eag_mode_based_index: begin
                next_state.resp.offset = 16'(base_val + index_val + disp_ext); // see RULE8 see RULE22
                if (req.base_sel == eag_base_pointer) begin
                    dflt = eag_seg_stack; // see RULE2
                end
            end
            eag_mode_string: begin
                // full 16-bit pointer so a string may cover the whole segment
                next_state.resp.offset = req.str_dest ? regs.dest_index_reg : regs.source_index_reg; // see RULE9 see RULE12
                dflt = req.str_dest ? eag_seg_extra : eag_seg_data; // see RULE11
                next_state.resp.index_upd = req.str_repeat; // see RULE10
                next_state.resp.next_source_index = req.str_down ?
                    16'(regs.source_index_reg - step) : 16'(regs.source_index_reg + step); // see RULE10
                next_state.resp.next_dest_index = req.str_down ?
                    16'(regs.dest_index_reg - step) : 16'(regs.dest_index_reg + step); // see RULE10
            end
            eag_mode_io_direct: begin
                next_state.resp.offset = {8'h00, req.disp[`EAG_PORT_DIRECT_W-1:0]}; // see RULE14
                next_state.resp.is_io = 1'b1;
            end
            eag_mode_io_indirect: begin
                next_state.resp.offset = regs.port_pointer_reg; // see RULE15
                next_state.resp.is_io = 1'b1;
            end
        endcase
        // string destination cannot be overridden; other memory forms can
        if (req.override && !(req.mode == eag_mode_string && req.str_dest)) begin
            next_state.resp.seg = req.override_seg; // see RULE2
        end else begin
            next_state.resp.seg = dflt;
        end
        unique case (next_state.resp.seg)
            eag_seg_extra: seg_val = regs.extra_segment_reg;
            eag_seg_stack: seg_val = regs.stack_segment_reg;
            default: seg_val = regs.data_segment_reg;
        endcase
        // memory-mapped ports need nothing extra: same path as memory
        next_state.resp.phys = next_state.resp.is_io ? {4'h0, next_state.resp.offset} :
            phys_of(seg_val, next_state.resp.offset); // see RULE13 see RULE19 see RULE20
        next_lp_phys = phys_of(ptr_selector, ptr_offset); // see RULE18
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= '0;
            lp_phys <= '0;
            bcd_lo <= '0;
            bcd_hi <= '0;
            sx <= `EAG_ZERO16;
        end else begin
            state <= next_state;
            lp_phys <= next_lp_phys;
            bcd_lo <= {4'h0, req.disp[`EAG_BCD_DIGIT_W-1:0]}; // see RULE17
            bcd_hi <= {4'h0, req.disp[7:`EAG_BCD_DIGIT_W]}; // see RULE17
            sx <= req.disp_wide ? req.disp : {{8{req.disp[7]}}, req.disp[7:0]}; // see RULE16
        end
    end

    assign resp = state.resp;
    assign long_ptr_phys = lp_phys;
    assign bcd_low_digit = bcd_lo;
    assign bcd_high_digit = bcd_hi;
    assign sext_disp = sx;
endmodule

// ===== tb/eag_core_chk.sv
// Purpose: port checks for the effective address generator
// Assumes: one-cycle registered answer
// Notes: helper flops keep the previous request
`timescale 1ns/10ps
module eag_core_chk
    import eag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire eag_req_type req,
    input wire eag_regs_type regs,
    input wire logic [15:0] ptr_selector,
    input wire logic [15:0] ptr_offset,
    input wire eag_resp_type resp,
    input wire logic [19:0] long_ptr_phys,
    input wire logic [7:0] bcd_low_digit,
    input wire logic [7:0] bcd_high_digit,
    input wire logic [15:0] sext_disp
);
    // ****
    // checks
    // ****
    logic was_up;
    eag_req_type q;
    always_ff @(posedge clk_sys) begin
        was_up <= rst_b;
        q <= req;
    end
    function automatic logic [15:0] segof(eag_seg_type s, eag_regs_type r);
        return s == eag_seg_extra ? r.extra_segment_reg : s == eag_seg_stack ? r.stack_segment_reg : r.data_segment_reg;
    endfunction
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    chk_direct_disp: assert property (was_up && q.mode == eag_mode_direct && q.disp_wide |-> resp.offset == q.disp)
        else $error("direct offset wrong");
    chk_stack_default: assert property (was_up && q.valid && q.mode == eag_mode_based && q.base_sel == eag_base_pointer
        && !q.override |-> resp.seg == eag_seg_stack) else $error("pointer base segment wrong");
    chk_data_default: assert property (was_up && q.mode == eag_mode_indexed && !q.override |-> resp.seg == eag_seg_data)
        else $error("indexed segment wrong");
    chk_phys_form: assert property (resp.valid && !resp.is_io && resp.seg != eag_seg_code
        |-> resp.phys == {segof(resp.seg, $past(regs)), 4'h0} + resp.offset) else $error("physical address wrong");
    chk_port_direct: assert property (was_up && q.mode == eag_mode_io_direct |-> resp.phys == {12'h0, q.disp[7:0]})
        else $error("direct port wrong");
    chk_port_indirect: assert property (was_up && q.mode == eag_mode_io_indirect
        |-> resp.phys == {4'h0, $past(regs.port_pointer_reg)}) else $error("indirect port wrong");
    chk_bcd_nibbles: assert property (was_up |-> {bcd_high_digit, bcd_low_digit} == {4'h0, q.disp[7:4], 4'h0, q.disp[3:0]})
        else $error("digit split wrong");
    chk_long_ptr: assert property (was_up |-> long_ptr_phys == {$past(ptr_selector), 4'h0} + $past(ptr_offset))
        else $error("long pointer wrong");
    chk_short_sext: assert property (was_up && !q.disp_wide |-> sext_disp == {{8{q.disp[7]}}, q.disp[7:0]})
        else $error("short displacement wrong");
    cover property (resp.index_upd);
    cover property (resp.valid && resp.is_io);
    cover property (resp.seg == eag_seg_stack);
endmodule
bind eag_core eag_core_chk eag_core_chk_inst (.clk_sys, .rst_b, .req, .regs, .ptr_selector, .ptr_offset, .resp,
    .long_ptr_phys, .bcd_low_digit, .bcd_high_digit, .sext_disp);

// ===== tb/eag_regs_model.sv
// Purpose: register file side of the address generator
// Assumes: writes index updates back as the caller would
// Notes: only the two index registers move
`timescale 1ns/10ps
module eag_regs_model
    import eag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire eag_resp_type resp,
    output eag_regs_type regs
);
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            regs <= {16'h1000, 16'h0010, 16'h0200, 16'h0300, 16'habcd, 16'h1000, 16'h2000, 16'h3000,
                128'h77776666555544443333222211110000};
        end else if (resp.valid && resp.index_upd) begin
            regs.source_index_reg <= resp.next_source_index;
            regs.dest_index_reg <= resp.next_dest_index;
        end
    end
endmodule

// ===== tb/test_effective_address_generator.sv
// Purpose: self-checking bench for the address generator
// Assumes: model feeds the register file
// Notes: step holds each request for two edges
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_effective_address_generator
    import eag_pkg::*;
;
    // ****
    // bench
    // ****
    typedef struct packed {logic [2:0] m; logic b; logic x; logic [1:0] s; logic [2:0] a; logic w; logic [15:0] d;
        logic io; logic [15:0] off; logic [1:0] seg;} eag_row_type;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    eag_req_type req = '0;
    eag_req_type r = '0;
    eag_regs_type regs;
    eag_resp_type resp;
    logic [15:0] ptr_selector = '0;
    logic [15:0] ptr_offset = '0;
    int num_errors = 0;
    int total_checks = 0;
    eag_row_type rows [9] = '{
        '{3'h0,1'h0,1'h0,2'h0,3'h0,1'h1,16'h1234,1'h0,16'h1234,2'h0},
        '{3'h1,1'h0,1'h0,2'h0,3'h0,1'h0,16'h0000,1'h0,16'h1000,2'h0},
        '{3'h1,1'h0,1'h0,2'h2,3'h5,1'h0,16'h0000,1'h0,16'h5555,2'h0},
        '{3'h2,1'h1,1'h0,2'h0,3'h0,1'h0,16'h00ff,1'h0,16'h000f,2'h2},
        '{3'h2,1'h0,1'h0,2'h0,3'h0,1'h1,16'hfff0,1'h0,16'h0ff0,2'h0},
        '{3'h3,1'h0,1'h1,2'h0,3'h0,1'h0,16'h0080,1'h0,16'h0280,2'h0},
        '{3'h4,1'h1,1'h0,2'h0,3'h0,1'h1,16'h0004,1'h0,16'h0214,2'h2},
        '{3'h6,1'h0,1'h0,2'h0,3'h0,1'h0,16'h01ff,1'h1,16'h00ff,2'h0},
        '{3'h7,1'h0,1'h0,2'h0,3'h0,1'h0,16'h0000,1'h1,16'habcd,2'h0}};
    always #2 clk_sys = ~clk_sys;
    eag_core eag_core_inst (.clk_sys, .rst_b, .req, .regs, .ptr_selector, .ptr_offset, .resp,
        .long_ptr_phys(), .bcd_low_digit(), .bcd_high_digit(), .sext_disp());
    eag_regs_model eag_regs_model_inst (.clk_sys, .rst_b, .resp, .regs);
    task automatic step(input eag_req_type v);
        @(posedge clk_sys);
        req <= v;
        ptr_selector <= v.disp;
        ptr_offset <= ~v.disp;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            r = '0;
            r.valid = 1'b1;
            r.mode = eag_mode_type'(rows[i].m);
            r.base_sel = eag_base_type'(rows[i].b);
            r.index_sel = eag_index_type'(rows[i].x);
            r.ind_src = eag_ind_type'(rows[i].s);
            r.any_reg = rows[i].a;
            r.disp_wide = rows[i].w;
            r.disp = rows[i].d;
            step(r);
            if (rows[i].io) `CHK("port", {4'h0, rows[i].off}, resp.phys)
            else `CHK("ea", {rows[i].seg, rows[i].off}, {resp.seg, resp.offset})
            $display("row %0d done", i);
        end
        r = '0;
        r.valid = 1'b1;
        r.mode = eag_mode_string;
        r.str_word = 1'b1;
        r.str_repeat = 1'b1;
        step(r);
        `CHK("str src", {eag_seg_data, 16'h0200}, {resp.seg, resp.offset})
        `CHK("str upd", {1'b1, 16'h0202, 16'h0302}, {resp.index_upd, resp.next_source_index, resp.next_dest_index})
        step('0);
        r.str_dest = 1'b1;
        r.str_repeat = 1'b0;
        r.override = 1'b1;
        r.override_seg = eag_seg_stack;
        step(r);
        // write-back lags one edge, so the held request steps from the same old value twice
        `CHK("str dst", {eag_seg_extra, 16'h0302}, {resp.seg, resp.offset})
        $display("string test done");
        @(posedge clk_sys);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK("reset", 21'h0, {resp.valid, resp.phys})
        rst_b <= 1'b1;
        $display("reset test done");
        tally_and_finish;
    end
endmodule
